// File: dv/wld_core_asserts.sv
// Checker for wld_core: handshake timing and error hold.
// Sees only the core's ports; attached by the bind below.
`timescale 1ns/1ps
module wld_core_asserts #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic instr_valid_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic error_lamp_o,
    input wire logic exec_error_relay_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Accept and finish events
    sequence s_accept;
        instr_valid_i && !busy_o;
    endsequence
    sequence s_finish;
        $fell(busy_o) && done_o;
    endsequence

    a_accept_busy: assert property (s_accept |=> busy_o)
        else $error("busy missing after accept");
    a_done_bound: assert property (s_accept |-> ##[5:320] done_o)
        else $error("done late after accept");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_busy_to_done: assert property ($fell(busy_o) |-> done_o)
        else $error("busy fell without done");
    a_done_ends_busy: assert property (done_o |-> s_finish)
        else $error("done without end of busy");
    a_error_held: assert property (error_lamp_o |=> error_lamp_o)
        else $error("lamp dropped");
    a_lamp_relay: assert property (error_lamp_o == exec_error_relay_o)
        else $error("lamp and relay differ");
    a_error_in_run: assert property ($rose(error_lamp_o) |-> s_finish)
        else $error("error did not end the instruction");
endmodule : wld_core_asserts

bind wld_core wld_core_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .instr_valid_i(instr_valid_i), .busy_o(busy_o), .done_o(done_o), .error_lamp_o(error_lamp_o),
    .exec_error_relay_o(exec_error_relay_o));

// File: dv/wld_core_bench.sv
// Bench for wld_core: word logic, divide repeat modes, error hold.
// Instructions go through the scan model; operands via the store port.
`timescale 1ns/1ps
module wld_core_bench;
    import wld_pkg::*;
    logic        clk_i, resetn_i, go, ext_we_i, instr_valid_i, lamp_exp;
    logic        busy_o, done_o, error_lamp_o, exec_error_relay_o;
    logic [7:0]  ext_addr_i;
    logic [15:0] ext_wdata_i, ext_rdata_o, seed, x, y, v;
    wld_instr_t  ins, instr_i;
    wld_op_t     op;
    int          num_errors, comparisons, t;

    wld_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .ext_we_i(ext_we_i), .ext_addr_i(ext_addr_i), .ext_wdata_i(ext_wdata_i), .ext_rdata_o(ext_rdata_o),
        .busy_o(busy_o), .done_o(done_o), .error_lamp_o(error_lamp_o), .exec_error_relay_o(exec_error_relay_o));
    wld_scan_model u_scan (.clk_i(clk_i), .resetn_i(resetn_i), .go_i(go), .instr_in_i(ins), .busy_i(busy_o),
        .instr_valid_o(instr_valid_i), .instr_o(instr_i));

    // Clock, 100 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic wld_instr_t mk(input wld_op_t o, input logic f1, input logic f2, input logic fd,
                                      input logic [4:0] c, input logic pre);
        return '{o, 8'h10, 8'h30, 8'h50, f1, f2, fd, c, pre};
    endfunction : mk
    task automatic test_done;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_w
    task automatic chk_b(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_b
    // Store port: write burst, then read with two-edge latency
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        ext_we_i <= 1'b1;
        ext_addr_i <= a;
        ext_wdata_i <= d;
    endtask : wr
    task automatic rd_w(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        ext_we_i <= 1'b0;
        ext_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1 d = ext_rdata_o;
    endtask : rd_w
    // One instruction, bounded wait for done
    task automatic run(input wld_instr_t i);
        int n;
        @(posedge clk_i);
        ext_we_i <= 1'b0;
        ins <= i;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        #1;
        for (n = 0; n < 400 && done_o !== 1'b1; n++) @(posedge clk_i) #1;
        if (n >= 400)
        begin
            num_errors++;
            $display("BAD %0t no done", $time);
            test_done();
        end
    endtask : run
    // Divide with repeat flags, count c, zero divisor at index zi
    task automatic div_case(input logic f1, input logic f2, input logic fd, input int c, input int zi);
        logic [15:0] a [8];
        logic [15:0] b [8];
        logic [15:0] e [16];
        logic        er;
        int          k;
        int          n;
        n = (c == 0) ? 1 : c;
        er = 1'b0;
        for (k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            a[k] = seed;
            seed = lfsr(seed);
            b[k] = (k == zi) ? 16'h0000 : {8'h00, seed[7:0] | 8'h01};
            wr(8'(8'h10 + k), a[k]);
            wr(8'(8'h30 + k), b[k]);
        end
        for (k = 0; k < 16; k++)
        begin
            e[k] = 16'hbeef;
            wr(8'(8'h50 + k), e[k]);
        end
        for (k = 0; k < n; k++)
        begin
            er |= (b[f2 ? k : 0] == 16'h0000);
            e[fd ? k : 0] = a[f1 ? k : 0] / b[f2 ? k : 0];
            e[fd ? n + k : 1] = a[f1 ? k : 0] % b[f2 ? k : 0];
        end
        for (k = 0; k < 16; k++) if (er) e[k] = 16'hbeef;
        run(mk(OP_DIV, f1, f2, fd, 5'(c), 1'b0));
        lamp_exp |= er;
        chk_b(error_lamp_o, lamp_exp);
        chk_b(exec_error_relay_o, lamp_exp);
        for (k = 0; k < 16; k++)
        begin
            rd_w(8'(8'h50 + k), v);
            chk_w(v, e[k]);
        end
        $display("divide test done");
    endtask : div_case

    // Main sequence
    initial
    begin
        resetn_i = 1'b0;
        go = 1'b0;
        ext_we_i = 1'b0;
        ext_addr_i = 8'h00;
        ext_wdata_i = 16'h0000;
        ins = '0;
        seed = 16'h07fd;
        lamp_exp = 1'b0;
        num_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 chk_b(error_lamp_o, 1'b0);
        // Word logic, random with complement corners
        for (t = 0; t < 12; t++)
        begin
            seed = lfsr(seed);
            x = seed;
            seed = lfsr(seed);
            y = (t < 3) ? ~x : seed;
            op = wld_op_t'(1 + t % 3);
            wr(8'h10, x);
            wr(8'h30, y);
            run(mk(op, 1'b0, 1'b0, 1'b0, 5'h01, 1'b0));
            rd_w(8'h50, v);
            chk_w(v, op == OP_AND ? x & y : op == OP_OR ? x | y : x ^ y);
        end
        // Boolean repeat: first source and destination step together
        for (t = 0; t < 3; t++) wr(8'(8'h10 + t), 16'(t * 16'h1111));
        wr(8'h30, 16'h0f0f);
        run(mk(OP_XOR, 1'b1, 1'b0, 1'b1, 5'h03, 1'b0));
        for (t = 0; t < 3; t++)
        begin
            rd_w(8'(8'h50 + t), v);
            chk_w(v, 16'(t * 16'h1111) ^ 16'h0f0f);
        end
        $display("word test done");
        // Every repeat combination, count of seven, zero count
        for (t = 0; t < 8; t++) div_case(t[0], t[1], t[2], 3, 8);
        div_case(1'b1, 1'b1, 1'b1, 7, 8);
        div_case(1'b0, 1'b0, 1'b1, 0, 8);
        // Preset limit: boundary stored, one above refused
        wr(8'h10, 16'h270f);
        wr(8'h30, 16'hffff);
        run(mk(OP_AND, 1'b0, 1'b0, 1'b0, 5'h01, 1'b1));
        rd_w(8'h50, v);
        chk_w(v, 16'h270f);
        chk_b(error_lamp_o, 1'b0);
        wr(8'h10, 16'h2710);
        run(mk(OP_AND, 1'b0, 1'b0, 1'b0, 5'h01, 1'b1));
        rd_w(8'h50, v);
        chk_w(v, 16'h270f);
        chk_b(exec_error_relay_o, 1'b1);
        lamp_exp = 1'b1;
        $display("preset test done");
        // Zero divisor in second cycle, then normal work goes on
        div_case(1'b0, 1'b1, 1'b1, 3, 1);
        div_case(1'b1, 1'b0, 1'b0, 2, 8);
        test_done();
    end
endmodule : wld_core_bench

// File: dv/wld_scan_model.sv
// Scan model: presents one instruction per request, as a ladder scan does.
// Assumes the core takes a request on an edge where it is not busy.
`timescale 1ns/1ps
module wld_scan_model (
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire logic                go_i,
    input  wire wld_pkg::wld_instr_t instr_in_i,
    input  wire logic                busy_i,
    output logic                     instr_valid_o,
    output wld_pkg::wld_instr_t      instr_o
);
    import wld_pkg::*;
    // Single-pulse condition: held until taken, then dropped
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            instr_valid_o <= 1'b0;
        else if (go_i)
            instr_valid_o <= 1'b1;
        else if (!busy_i)
            instr_valid_o <= 1'b0;
    end
    // Word follows each request, inverted once released
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            instr_o <= '0;
        else if (go_i)
            instr_o <= instr_in_i;
        else if (instr_valid_o && !busy_i)
            instr_o <= wld_instr_t'(~instr_o);
    end
endmodule : wld_scan_model

// File: verilog/wld_core.sv
// Word Boolean and divide datapath with repeat sequencing and error hold.
// Assumes the scan engine issues one instruction at a time while busy is low.
//
// Function
// - Divide puts quotient at destination, remainder at the next operand.
// - Unrepeated destination keeps only the last cycle's result.
// - Repeated operands step one address per cycle from their base.
// - Source-only repeat divides each pair, final quotient and remainder kept.
// - Destination-only repeat writes same quotient block then same remainder block.
// - Repeated destination with repeated source stores cycle i at i and count+i.
// - Any execution error lights lamp and relay, both held; others continue.
// - An instruction with an error writes no destination at all.
// - Boolean words execute every time the input condition is presented.
// - Word AND sets a bit only when both source bits are one.
// - Word OR clears a bit only when both source bits are zero.
// - Word XOR sets a bit where the two source bits differ.
// - Preset destination above 9999 is an error and is not stored.
`timescale 1ns/1ps
module wld_core #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire logic                instr_valid_i,
    input  wire wld_pkg::wld_instr_t instr_i,
    input  wire logic                ext_we_i,
    input  wire logic [ADDR_W-1:0]   ext_addr_i,
    input  wire logic [DATA_W-1:0]   ext_wdata_i,
    output logic      [DATA_W-1:0]   ext_rdata_o,
    output logic                     busy_o,
    output logic                     done_o,
    output logic                     error_lamp_o,
    output logic                     exec_error_relay_o
);
    import wld_pkg::*;

    wld_state_t         state_ff;
    wld_state_t         nxt_state;
    wld_instr_t         instr_ff;
    logic [REP_W-1:0]   idx_ff;
    logic               commit_ff;     // Low: checking pass, high: writing pass
    logic [DATA_W-1:0]  opa_ff;
    logic [DATA_W-1:0]  opb_ff;
    logic [DATA_W-1:0]  res_q_ff;
    logic [DATA_W-1:0]  res_r_ff;
    logic               err_ff;
    logic               busy_ff;
    logic               done_ff;
    logic [REP_W-1:0]   last_idx;
    logic [ADDR_W-1:0]  idx_w;
    logic [ADDR_W-1:0]  rep_w;
    logic [ADDR_W-1:0]  addr_a;
    logic [ADDR_W-1:0]  addr_b;
    logic [ADDR_W-1:0]  addr_q;
    logic [ADDR_W-1:0]  addr_r;
    logic [DATA_W-1:0]  calc_q;
    logic [DATA_W-1:0]  calc_r;
    logic               calc_err;
    logic               ram_we;
    logic [ADDR_W-1:0]  ram_waddr;
    logic [DATA_W-1:0]  ram_wdata;
    logic [ADDR_W-1:0]  ram_raddr;
    logic [DATA_W-1:0]  ram_rdata;

    // Repeat count of zero behaves as a single cycle
    assign last_idx = (instr_ff.repeat_count == '0) ? '0 : instr_ff.repeat_count - REP_ONE;
    assign idx_w    = ADDR_W'(idx_ff);
    assign rep_w    = (instr_ff.repeat_count == '0) ? ADDR_ONE : ADDR_W'(instr_ff.repeat_count);

    // Operand addresses for the current cycle
    assign addr_a = instr_ff.first_source + (instr_ff.rep_first ? idx_w : '0);
    assign addr_b = instr_ff.second_source + (instr_ff.rep_second ? idx_w : '0);
    assign addr_q = instr_ff.dest_operand + (instr_ff.rep_dest ? idx_w : '0);
    assign addr_r = instr_ff.rep_dest ? instr_ff.dest_operand + rep_w + idx_w
                                      : instr_ff.dest_operand + ADDR_ONE;

    // Arithmetic and Boolean results with error detection
    always_comb
    begin
        calc_q   = '0;
        calc_r   = '0;
        calc_err = 1'b0;
        case (instr_ff.op)
            OP_DIV:
            begin
                if (opb_ff == '0)
                begin
                    calc_err = 1'b1;
                end
                else
                begin
                    calc_q = opa_ff / opb_ff;
                    calc_r = opa_ff % opb_ff;
                end
            end
            OP_AND:  calc_q = opa_ff & opb_ff;
            OP_OR:   calc_q = opa_ff | opb_ff;
            OP_XOR:  calc_q = opa_ff ^ opb_ff;
            default: calc_err = 1'b1;
        endcase
        if (instr_ff.dest_is_preset && (calc_q > PRESET_MAX ||
            (instr_ff.op == OP_DIV && calc_r > PRESET_MAX)))
        begin
            calc_err = 1'b1;
        end
    end

    // Next state of the sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (instr_valid_i)
                begin
                    nxt_state = ST_RD_A;
                end
            end
            ST_RD_A:  nxt_state = ST_RD_B;
            ST_RD_B:  nxt_state = ST_LATCH;
            ST_LATCH: nxt_state = ST_CALC;
            ST_CALC:
            begin
                if (!commit_ff)
                begin
                    if (calc_err)
                    begin
                        nxt_state = ST_IDLE;
                    end
                    else
                    begin
                        nxt_state = ST_RD_A;
                    end
                end
                else
                begin
                    nxt_state = ST_WR_Q;
                end
            end
            ST_WR_Q:
            begin
                if (instr_ff.op == OP_DIV)
                begin
                    nxt_state = ST_WR_R;
                end
                else if (idx_ff == last_idx)
                begin
                    nxt_state = ST_IDLE;
                end
                else
                begin
                    nxt_state = ST_RD_A;
                end
            end
            ST_WR_R:
            begin
                if (idx_ff == last_idx)
                begin
                    nxt_state = ST_IDLE;
                end
                else
                begin
                    nxt_state = ST_RD_A;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Instruction capture, one at a time
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            instr_ff <= '0;
        end
        else if (state_ff == ST_IDLE && instr_valid_i)
        begin
            instr_ff <= instr_i;
        end
    end

    // Cycle index and pass: check all cycles, then replay them with writes
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            idx_ff    <= '0;
            commit_ff <= 1'b0;
        end
        else if (state_ff == ST_IDLE)
        begin
            idx_ff    <= '0;
            commit_ff <= 1'b0;
        end
        else if (state_ff == ST_CALC && !commit_ff && !calc_err)
        begin
            if (idx_ff == last_idx)
            begin
                idx_ff    <= '0;
                commit_ff <= 1'b1;
            end
            else
            begin
                idx_ff <= idx_ff + REP_ONE;
            end
        end
        else if ((state_ff == ST_WR_Q && instr_ff.op != OP_DIV) || state_ff == ST_WR_R)
        begin
            idx_ff <= idx_ff + REP_ONE;
        end
    end

    // Operand capture from the registered read port
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            opa_ff <= '0;
            opb_ff <= '0;
        end
        else if (state_ff == ST_RD_B)
        begin
            opa_ff <= ram_rdata;
        end
        else if (state_ff == ST_LATCH)
        begin
            opb_ff <= ram_rdata;
        end
    end

    // Result hold for the write states
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            res_q_ff <= '0;
            res_r_ff <= '0;
        end
        else if (state_ff == ST_CALC)
        begin
            res_q_ff <= calc_q;
            res_r_ff <= calc_r;
        end
    end

    // Sticky error, held until reset; other instructions still run
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            err_ff <= 1'b0;
        end
        else if (state_ff == ST_CALC && calc_err)
        begin
            err_ff <= 1'b1;
        end
    end

    // Busy and completion pulse
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            busy_ff <= (nxt_state != ST_IDLE);
            done_ff <= (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
        end
    end

    // Storage port steering; outside the sequence the external port owns it
    always_comb
    begin
        ram_we    = 1'b0;
        ram_waddr = ext_addr_i;
        ram_wdata = ext_wdata_i;
        ram_raddr = ext_addr_i;
        case (state_ff)
            ST_IDLE:
            begin
                ram_we = ext_we_i && !instr_valid_i;
            end
            ST_RD_A: ram_raddr = addr_a;
            ST_RD_B: ram_raddr = addr_b;
            ST_WR_Q:
            begin
                ram_we    = 1'b1;
                ram_waddr = addr_q;
                ram_wdata = res_q_ff;
            end
            ST_WR_R:
            begin
                ram_we    = 1'b1;
                ram_waddr = addr_r;
                ram_wdata = res_r_ff;
            end
            default: ram_raddr = ext_addr_i;
        endcase
    end

    wld_operand_ram #(
        .DATA_W (DATA_W),
        .ADDR_W (ADDR_W)
    ) u_ram (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .we_i     (ram_we),
        .waddr_i  (ram_waddr),
        .wdata_i  (ram_wdata),
        .raddr_i  (ram_raddr),
        .rdata_o  (ram_rdata)
    );

    assign ext_rdata_o        = ram_rdata;
    assign busy_o             = busy_ff;
    assign done_o             = done_ff;
    assign error_lamp_o       = err_ff;
    assign exec_error_relay_o = err_ff;

endmodule : wld_core

// File: verilog/wld_operand_ram.sv
// Operand store: one write port and one read port, read data registered.
// Assumes a single clock; no reset on the storage array itself.
`timescale 1ns/1ps
module wld_operand_ram #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [DATA_W-1:0] rdata_o
);

    logic [DATA_W-1:0] mem_ff [2**ADDR_W];
    logic [DATA_W-1:0] rdata_ff;

    // Write port
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_ff[waddr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= mem_ff[raddr_i];
        end
    end

    assign rdata_o = rdata_ff;

endmodule : wld_operand_ram

// File: verilog/wld_pkg.sv
// Shared types and constants for the word logic and divide datapath.
// Assumes one 10 MHz clock and synchronous operand storage.
package wld_pkg;

    localparam int            DATA_W       = 16;
    localparam int            ADDR_W       = 8;
    localparam int            REP_W        = 5;
    localparam logic [15:0]   PRESET_MAX   = 16'd9999;   // Largest timer or counter preset
    localparam logic [7:0]    ADDR_ONE     = 8'h01;
    localparam logic [4:0]    REP_ONE      = 5'h01;

    // Instruction kinds
    typedef enum logic [1:0] {
        OP_DIV  = 2'b00,
        OP_AND  = 2'b01,
        OP_OR   = 2'b10,
        OP_XOR  = 2'b11
    } wld_op_t;

    // One instruction as issued by the scan engine
    typedef struct packed {
        wld_op_t                op;
        logic [ADDR_W-1:0]      first_source;
        logic [ADDR_W-1:0]      second_source;
        logic [ADDR_W-1:0]      dest_operand;
        logic                   rep_first;
        logic                   rep_second;
        logic                   rep_dest;
        logic [REP_W-1:0]       repeat_count;
        logic                   dest_is_preset;
    } wld_instr_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RD_A  = 3'b001,
        ST_RD_B  = 3'b010,
        ST_LATCH = 3'b011,
        ST_CALC  = 3'b100,
        ST_WR_Q  = 3'b101,
        ST_WR_R  = 3'b110
    } wld_state_t;

endpackage : wld_pkg
